// [logic/cri_reset_init.sv]
// device-wide clear, reset release and register initialisation of one logic group
// assumes board_reset_n and device_wide_clear_n come straight from board pins;
// everything else is synchronous to core_clk
//
// Function
// - clear pin low forces every core register to zero, over all other clears.
// - clear pin also resets memory block registers but not the array contents.
// - inverted-storage registers show high while the clear pin is low.
// - clear pin high lets registers follow their own clock, enable, clear, load.
// - clear pin acts only when enabled at build time, otherwise ignored.
// - a group shares at most 3 clocks, 3 enables, 2 aclr, 1 sclr, 1 sload.
// - every core register holds zero right after power-up.
// - high reset or power-up values use inverted storage and the register clear.
// - power-up level against reset polarity cannot be honoured; flagged instead.
// - design reset asserts asynchronously, releases on the destination clock edge.
// - whole domain leaves reset on one clock edge, never near an edge.
// - no register gets both an asynchronous reset and asynchronous preset.
// - derived clock comes from a register clocked by the divider's own clock.
// - clock selection and gating use enables, never general gates.
`timescale 1ns/1ps
module cri_reset_init
    import cri_pkg::*;
#(
    parameter int          WIDTH        = 8,
    parameter logic [7:0]  RESET_HIGH   = 8'h00,
    parameter logic [7:0]  POWERUP_HIGH = 8'h00,
    parameter logic [15:0] CE_SELECT    = 16'hffff,
    parameter bit          CLEAR_ENABLE = 1'b0,
    parameter int          MEM_DEPTH    = 16,
    parameter int          DIV_RATIO    = 4
)
(
    // clock and resets
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                board_reset_n,
    input  wire logic                device_wide_clear_n,
    // logic group control set and data
    input  wire cri_grp_ctrl_t       grp_ctrl,
    input  wire logic [WIDTH-1:0]    grp_d,
    input  wire logic [WIDTH-1:0]    grp_load_data,
    // embedded memory port
    input  wire cri_mem_req_t        mem_req,
    // status and data out
    output logic [WIDTH-1:0]         grp_q,
    output logic [7:0]               mem_rd_data,
    output logic                     reset_released,
    output logic                     div_clk_out,
    output logic                     div_tick,
    output logic [WIDTH-1:0]         powerup_unmet
);

    localparam int          DIV_W    = (DIV_RATIO > 2) ? $clog2(DIV_RATIO) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_RATIO - 1);
    // bits kept inverted so a zero store reads as the wanted reset level
    localparam logic [WIDTH-1:0] INV_MASK = RESET_HIGH[WIDTH-1:0];
    // power-up wish opposes reset polarity: inversion cannot serve both
    localparam logic [WIDTH-1:0] UNMET_MASK =
        POWERUP_HIGH[WIDTH-1:0] ^ RESET_HIGH[WIDTH-1:0];

    // pin ignored unless built in
    logic clear_active;
    assign clear_active = CLEAR_ENABLE && !device_wide_clear_n;

    // release chain stores "released", so a zero store means reset active;
    // that way the device clear and the power-up zero both hold the domain in reset
    logic rel_stage1_reg = STORE_POWER_UP;
    logic rel_stage2_reg = STORE_POWER_UP;
    logic rel_stage1_next;
    logic rel_stage2_next;
    logic chain_aclr;

    assign chain_aclr = !board_reset_n || clear_active;

    always_comb
    begin
        rel_stage1_next = REL_INACTIVE;
        rel_stage2_next = rel_stage1_reg;
    end

    always_ff @(posedge core_clk or posedge chain_aclr)
    begin
        if (chain_aclr)
        begin
            rel_stage1_reg <= REL_ACTIVE;
            rel_stage2_reg <= REL_ACTIVE;
        end
        else
        begin
            rel_stage1_reg <= rel_stage1_next;
            rel_stage2_reg <= rel_stage2_next;
        end
    end

    // the two asynchronous clears of the group: synced design reset and device clear
    logic grp_aclr;
    assign grp_aclr = clear_active || (rel_stage2_reg == REL_ACTIVE);

    function automatic logic ce_of(input logic [1:0] sel,
                                   input logic [GRP_CLK_ENABLES-1:0] en);
        logic r;
        r = 1'b1;
        if (sel != CE_SEL_ALWAYS)
        begin
            r = en[sel];
        end
        return r;
    endfunction

    // group registers: clear only, never a preset
    logic [WIDTH-1:0] store_reg = '0;
    logic [WIDTH-1:0] store_next;
    logic [WIDTH-1:0] unmet_reg = '0;
    logic [WIDTH-1:0] unmet_next;

    always_comb
    begin
        logic [WIDTH-1:0] logical;
        logical = store_reg ^ INV_MASK;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (rst || grp_ctrl.sync_clr)
            begin
                logical[i] = RESET_HIGH[i];
            end
            else if (grp_ctrl.sync_load)
            begin
                logical[i] = grp_load_data[i];
            end
            else if (ce_of(CE_SELECT[2*i +: 2], grp_ctrl.clk_en))
            begin
                logical[i] = grp_d[i];
            end
        end
        store_next = logical ^ INV_MASK;
        unmet_next = UNMET_MASK;
    end

    always_ff @(posedge core_clk or posedge grp_aclr)
    begin
        if (grp_aclr)
        begin
            store_reg <= '0;
            unmet_reg <= '0;
        end
        else
        begin
            store_reg <= store_next;
            unmet_reg <= unmet_next;
        end
    end

    // output inverter belongs to the cell; inverted bits read high under clear
    assign grp_q         = store_reg ^ INV_MASK;
    assign powerup_unmet = unmet_reg;
    assign reset_released = rel_stage2_reg;

    // embedded memory: array carries no reset, only its port registers do
    logic [7:0]  mem_array [MEM_DEPTH];
    logic [3:0]  rd_addr_reg = '0;
    logic [3:0]  rd_addr_next;
    logic [7:0]  rd_data_reg = '0;
    logic [7:0]  rd_data_next;

    always_ff @(posedge core_clk)
    begin
        if (mem_req.wr_en && (rel_stage2_reg == REL_INACTIVE) && !clear_active)
        begin
            mem_array[mem_req.wr_addr] <= mem_req.wr_data;
        end
    end

    always_comb
    begin
        rd_addr_next = rst ? 4'h0 : mem_req.rd_addr;
        rd_data_next = rst ? 8'h00 : mem_array[rd_addr_reg];
    end

    always_ff @(posedge core_clk or posedge grp_aclr)
    begin
        if (grp_aclr)
        begin
            rd_addr_reg <= 4'h0;
            rd_data_reg <= 8'h00;
        end
        else
        begin
            rd_addr_reg <= rd_addr_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign mem_rd_data = rd_data_reg;

    // divider: final stage is a flop on core_clk, so the derived clock cannot glitch
    logic [DIV_W-1:0] div_cnt_reg = '0;
    logic [DIV_W-1:0] div_cnt_next;
    logic             div_clk_reg = 1'b0;
    logic             div_clk_next;
    logic             div_tick_reg = 1'b0;
    logic             div_tick_next;

    always_comb
    begin
        div_tick_next = (div_cnt_reg == DIV_LAST);
        div_cnt_next  = div_tick_next ? '0 : div_cnt_reg + 1'b1;
        div_clk_next  = div_tick_next ? !div_clk_reg : div_clk_reg;
        if (rst)
        begin
            div_tick_next = 1'b0;
            div_cnt_next  = '0;
            div_clk_next  = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge grp_aclr)
    begin
        if (grp_aclr)
        begin
            div_cnt_reg  <= '0;
            div_clk_reg  <= 1'b0;
            div_tick_reg <= 1'b0;
        end
        else
        begin
            div_cnt_reg  <= div_cnt_next;
            div_clk_reg  <= div_clk_next;
            div_tick_reg <= div_tick_next;
        end
    end

    assign div_clk_out = div_clk_reg;
    assign div_tick    = div_tick_reg;

endmodule

// [logic/cri_pkg.sv]
// shared constants and carriers for the reset and register-init block
// assumes one core clock per reset domain and a single logic group per instance
package cri_pkg;

    // dedicated control resources of one logic group
    localparam int GRP_CLOCKS      = 3;
    localparam int GRP_CLK_ENABLES = 3;
    localparam int GRP_ASYNC_CLRS  = 2;
    localparam int GRP_SYNC_CLRS   = 1;
    localparam int GRP_SYNC_LOADS  = 1;

    // release synchroniser depth
    localparam int SYNC_STAGES = 2;

    // physical core registers come up low
    localparam logic STORE_POWER_UP = 1'b0;

    // storage level meaning "reset still active" in the release chain
    localparam logic REL_ACTIVE   = 1'b0;
    localparam logic REL_INACTIVE = 1'b1;

    // clock enable selector codes per register bit
    localparam logic [1:0] CE_SEL_ALWAYS = 2'h3;

    // shared control set of one logic group
    typedef struct packed {
        logic [GRP_CLK_ENABLES-1:0] clk_en;
        logic                       sync_clr;
        logic                       sync_load;
    } cri_grp_ctrl_t;

    // write and read-address port of the embedded memory
    typedef struct packed {
        logic       wr_en;
        logic [3:0] wr_addr;
        logic [7:0] wr_data;
        logic [3:0] rd_addr;
    } cri_mem_req_t;

endpackage

// [verif/cri_reset_init_assertions.sv]
// checker for the reset and register-init block
// assumes a bind to cri_reset_init with its parameters handed on
`timescale 1ns/1ps
module cri_reset_init_assertions
    import cri_pkg::*;
#(
    parameter int         WIDTH        = 8,
    parameter logic [7:0] RESET_HIGH   = 8'h00,
    parameter logic [7:0] POWERUP_HIGH = 8'h00,
    parameter bit         CLEAR_ENABLE = 1'b0
)
(
    // clock and resets
    input wire logic             core_clk,
    input wire logic             rst,
    input wire logic             board_reset_n,
    input wire logic             device_wide_clear_n,
    // group inputs
    input wire cri_grp_ctrl_t    grp_ctrl,
    input wire logic [WIDTH-1:0] grp_load_data,
    // outputs
    input wire logic [WIDTH-1:0] grp_q,
    input wire logic [7:0]       mem_rd_data,
    input wire logic             reset_released,
    input wire logic             div_clk_out,
    input wire logic             div_tick,
    input wire logic [WIDTH-1:0] powerup_unmet
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    wire logic run = board_reset_n & device_wide_clear_n & reset_released;

    a_clear_forces_reset: assert property (CLEAR_ENABLE && !device_wide_clear_n |->
        grp_q == RESET_HIGH && mem_rd_data == 8'h00 && !reset_released)
        else $error("clear pin low but registers not cleared");
    a_board_reset_hold: assert property (!board_reset_n |-> grp_q == RESET_HIGH
        && !div_tick && !reset_released) else $error("design reset did not act at once");
    a_release_wait: assert property ($rose(reset_released) |-> $past(board_reset_n, 2)
        && $past(device_wide_clear_n, 2)) else $error("release came before two edges");
    a_load_takes: assert property (run && grp_ctrl.sync_load && !grp_ctrl.sync_clr ##1 run
        |-> grp_q == $past(grp_load_data)) else $error("load value not taken");
    a_sync_clear_value: assert property (run && grp_ctrl.sync_clr ##1 run
        |-> grp_q == RESET_HIGH) else $error("sync clear gave wrong value");
    a_tick_spacing: assert property (div_tick ##1 reset_released [*4] |-> div_tick)
        else $error("divider tick spacing wrong");
    a_tick_toggles_clk: assert property (div_tick |-> div_clk_out != $past(div_clk_out)
        ##1 !div_tick) else $error("divided clock not toggled by tick");
    a_powerup_flagged: assert property (reset_released && $past(reset_released, 2)
        |-> powerup_unmet == (POWERUP_HIGH ^ RESET_HIGH)) else $error("unmet flags wrong");
endmodule
bind cri_reset_init cri_reset_init_assertions #(.WIDTH(WIDTH), .RESET_HIGH(RESET_HIGH),
    .POWERUP_HIGH(POWERUP_HIGH), .CLEAR_ENABLE(CLEAR_ENABLE)) i_cri_reset_init_assertions (
    .core_clk(core_clk), .rst(rst), .board_reset_n(board_reset_n),
    .device_wide_clear_n(device_wide_clear_n), .grp_ctrl(grp_ctrl),
    .grp_load_data(grp_load_data), .grp_q(grp_q), .mem_rd_data(mem_rd_data),
    .reset_released(reset_released), .div_clk_out(div_clk_out), .div_tick(div_tick),
    .powerup_unmet(powerup_unmet));

// [verif/cri_board_model.sv]
// board reset source: design reset held through bring-up, clear pin on request
// assumes clear_req is synchronous to core_clk
`timescale 1ns/1ps
module cri_board_model
#(
    parameter int BRINGUP = 12
)
(
    // clock and request
    input  wire logic core_clk,
    input  wire logic clear_req,
    // board pins
    output logic      board_reset_n = 1'b0,
    output logic      device_wide_clear_n = 1'b1
);
    int cnt = 0;
    always @(posedge core_clk)
    begin
        cnt <= cnt + 1;
        // never rely on power-up state: release only after bring-up
        if (cnt == BRINGUP) board_reset_n <= 1'b1;
        device_wide_clear_n <= !clear_req;
    end
endmodule

// [verif/tb_cri_reset_init.sv]
// self-checking bench for the reset and register-init block
// assumes cri_board_model stands in for the board reset source
`timescale 1ns/1ps
module tb_cri_reset_init
    import cri_pkg::*;
;
    localparam logic [7:0] RH = 8'h0f;
    localparam logic [7:0] PH = 8'h03;
    logic          core_clk = 1'b0;
    logic          rst = 1'b1;
    logic          clear_req = 1'b0;
    cri_grp_ctrl_t grp_ctrl = '0;
    logic [7:0]    grp_d = 8'h00;
    logic [7:0]    grp_load_data = 8'h00;
    cri_mem_req_t  mem_req = '0;
    logic [7:0]    grp_q, mem_rd_data, powerup_unmet, exp, m;
    logic          board_reset_n, device_wide_clear_n, reset_released, div_clk_out, div_tick;
    logic [7:0]    ticks = 8'h00;
    int            n_errors = 0;
    int            compares = 0;
    int            cycles = 0;

    cri_board_model i_cri_board_model (.core_clk(core_clk), .clear_req(clear_req),
        .board_reset_n(board_reset_n), .device_wide_clear_n(device_wide_clear_n));
    // bit0..2 follow enables 0..2, the rest always enabled
    cri_reset_init #(.RESET_HIGH(RH), .POWERUP_HIGH(PH), .CE_SELECT(16'hffe4),
        .CLEAR_ENABLE(1'b1), .DIV_RATIO(4)) i_cri_reset_init (.core_clk(core_clk),
        .rst(rst), .board_reset_n(board_reset_n), .device_wide_clear_n(device_wide_clear_n),
        .grp_ctrl(grp_ctrl), .grp_d(grp_d), .grp_load_data(grp_load_data), .mem_req(mem_req),
        .grp_q(grp_q), .mem_rd_data(mem_rd_data), .reset_released(reset_released),
        .div_clk_out(div_clk_out), .div_tick(div_tick), .powerup_unmet(powerup_unmet));

    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wait_rel();
        repeat (30) if (reset_released !== 1'b1) @(posedge core_clk);
        #1 chk8("released", 8'h01, {7'h00, reset_released});
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (div_tick === 1'b1) ticks <= ticks + 8'h01;
        if (cycles == 3000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    initial
    begin
        #1 chk8("power-up q", RH, grp_q);
        cyc(10);
        rst <= 1'b0;
        wait_rel();
        cyc(1);
        grp_ctrl.sync_load <= 1'b1;
        grp_load_data <= 8'ha5;
        cyc(1);
        grp_ctrl.sync_load <= 1'b0;
        #1 chk8("loaded q", 8'ha5, grp_q);
        exp = 8'ha5;
        for (int e = 0; e < 3; e++)
        begin
            cyc(1);
            grp_ctrl.clk_en <= 3'b001 << e;
            grp_d <= 8'h5a;
            cyc(1);
            grp_ctrl.clk_en <= 3'b000;
            m = 8'hf8 | (8'h01 << e);
            exp = (exp & ~m) | (8'h5a & m);
            #1 chk8("enabled q", exp, grp_q);
        end
        cyc(1);
        grp_ctrl.sync_clr <= 1'b1;
        cyc(1);
        grp_ctrl.sync_clr <= 1'b0;
        #1 chk8("cleared q", RH, grp_q);
        chk8("unmet", RH ^ PH, powerup_unmet);
        cyc(1);
        mem_req <= '{1'b1, 4'h5, 8'h3c, 4'h0};
        cyc(1);
        mem_req <= '{1'b0, 4'h5, 8'h3c, 4'h5};
        cyc(2);
        #1 chk8("mem read", 8'h3c, mem_rd_data);
        cyc(1);
        clear_req <= 1'b1;
        // the pin falls one edge after the request, so the write waits until clear holds
        cyc(2);
        mem_req <= '{1'b1, 4'h5, 8'hff, 4'h5};
        cyc(1);
        #1 chk8("clear q", RH, grp_q);
        chk8("clear mem out", 8'h00, mem_rd_data);
        cyc(1);
        clear_req <= 1'b0;
        mem_req <= '{1'b0, 4'h5, 8'hff, 4'h5};
        wait_rel();
        cyc(3);
        #1 chk8("kept array", 8'h3c, mem_rd_data);
        exp = ticks;
        cyc(16);
        #1 chk8("ticks", 8'h04, ticks - exp);
        // one-edge synchronous reset in mid-run: group to reset level, port regs to zero
        rst <= 1'b1;
        cyc(1);
        rst <= 1'b0;
        #1 chk8("rst q", RH, grp_q);
        chk8("rst mem out", 8'h00, mem_rd_data);
        print_verdict();
    end
endmodule
